// *** logic/pta_defines.svh ***
// Constants for the priority table access block.
// Assumes inclusion by bare name from pta_prio_select, pta_top and the testbench.
`ifndef PTA_DEFINES_SVH
`define PTA_DEFINES_SVH

// Register indices; byte address is four times the index
`define PTA_IDX_VLAN_RD    16'h180E
`define PTA_IDX_VLAN_STS   16'h1810
`define PTA_IDX_TBL_CMD    16'h1811
`define PTA_IDX_TBL_WDATA  16'h1812
`define PTA_IDX_TBL_RDATA  16'h1813
`define PTA_IDX_TBL_STS    16'h1814

// Field positions
`define PTA_CMD_RNW_BIT    7
`define PTA_CMD_IDX_MSB    5
`define PTA_PRIO_MSB       2
`define PTA_PEND_BIT       0
`define PTA_VLAN_MSB       17
`define PTA_VLAN_MEM2_BIT  17
`define PTA_VLAN_UNT2_BIT  16
`define PTA_VLAN_MEM1_BIT  15
`define PTA_VLAN_UNT1_BIT  14
`define PTA_VLAN_MEM0_BIT  13
`define PTA_VLAN_UNT0_BIT  12
`define PTA_TOS_MSB        7
`define PTA_TOS_CP_LSB     2
`define PTA_TOS_PREC_LSB   5

// Reset values
`define PTA_CMD_RST        8'h00
`define PTA_PRIO_RST       3'h0
`define PTA_VLAN_RST       18'h00000
`define PTA_DATA_ZERO      32'h00000000

`endif

// *** logic/pta_pkg.sv ***
// Types shared by the priority table access block.
// Assumes nothing of its surroundings.
`default_nettype none
package pta_pkg;

  typedef enum logic [1:0] {
    PTA_IDLE   = 2'b00,
    PTA_ACCESS = 2'b01,
    PTA_DONE   = 2'b10
  } pta_state_t;

endpackage : pta_pkg

`default_nettype wire

// *** logic/pta_table_mem.sv ***
// Code point to priority table storage, host port and lookup port.
// Assumes one clock; contents are never reset.
`timescale 1ns/1ps
`default_nettype none

module pta_table_mem #(
  parameter int DEPTH = 64,
  parameter int WIDTH = 3,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock
  input  wire logic             clk,
  // Host port
  input  wire logic             host_en,
  input  wire logic             host_we,
  input  wire logic [AW-1:0]    host_addr,
  input  wire logic [WIDTH-1:0] host_wdata,
  output logic      [WIDTH-1:0] host_rdata,
  // Lookup port
  input  wire logic [AW-1:0]    lk_addr,
  output logic      [WIDTH-1:0] lk_rdata
);

  logic [WIDTH-1:0] table_mem [DEPTH];

  // No reset: contents undefined until written
  always_ff @(posedge clk) begin // RULE_11
    if (host_en && host_we) begin
      table_mem[host_addr] <= host_wdata;
    end
    if (host_en) begin
      host_rdata <= table_mem[host_addr];
    end
    lk_rdata <= table_mem[lk_addr];
  end

endmodule : pta_table_mem

`default_nettype wire

// *** logic/pta_prio_select.sv ***
// Transmit priority choice for IPv4 packets, precedence or table.
// Assumes the table answers one cycle after lk_addr.
`timescale 1ns/1ps
`default_nettype none
`include "pta_defines.svh"

module pta_prio_select (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Settings
  input  wire logic       use_ip,
  input  wire logic       use_precedence,
  // Packet side
  input  wire logic       ipv4_valid,
  input  wire logic [7:0] ipv4_tos,
  output logic            tx_prio_valid,
  output logic      [2:0] tx_prio,
  // Table lookup
  output logic      [5:0] lk_addr,
  input  wire logic [2:0] lk_prio
);

  logic       v1_reg, v1_next;
  logic       tbl1_reg, tbl1_next;
  logic [2:0] prec1_reg, prec1_next;
  logic       vo_reg, vo_next;
  logic [2:0] po_reg, po_next;

  assign lk_addr = ipv4_tos[`PTA_TOS_MSB:`PTA_TOS_CP_LSB];

  always_comb begin
    v1_next    = ipv4_valid && use_ip;
    tbl1_next  = !use_precedence;
    prec1_next = ipv4_tos[`PTA_TOS_MSB:`PTA_TOS_PREC_LSB];
    vo_next    = v1_reg;
    po_next    = tbl1_reg ? lk_prio : prec1_reg; // RULE_14
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      v1_reg    <= 1'b0;
      tbl1_reg  <= 1'b0;
      prec1_reg <= `PTA_PRIO_RST;
      vo_reg    <= 1'b0;
      po_reg    <= `PTA_PRIO_RST;
    end else begin
      v1_reg    <= v1_next;
      tbl1_reg  <= tbl1_next;
      prec1_reg <= prec1_next;
      vo_reg    <= vo_next;
      po_reg    <= po_next;
    end
  end

  assign tx_prio_valid = vo_reg;
  assign tx_prio       = po_reg;

  property p_prec_path;
    @(posedge clk) disable iff (reset)
    ipv4_valid && use_ip && use_precedence |-> ##2 tx_prio_valid && tx_prio == $past(ipv4_tos[7:5], 2);
  endproperty
  a_prec_path: assert property (p_prec_path) else $error("precedence priority wrong"); // RULE_14

endmodule : pta_prio_select

`default_nettype wire

// *** logic/pta_top.sv ***
// Host access to the code point priority table and VLAN status bits.
// Assumes an APB master on clk and a VLAN engine on the same clock.
//
// Behaviour
// (RULE_01) The VLAN status pending bit is set while a VLAN command runs and clears itself at its end.
// (RULE_02) Bit 16 of the VLAN read word is the port 2 un-tag flag for hybrid egress ports.
// (RULE_03) Bits 15 and 14 are port 1 member and un-tag, bits 13 and 12 are port 0 member and un-tag.
// (RULE_04) Each host write of the table command starts one access with that write's type and index; the code ignores writes while pending is set.
// (RULE_05) Command bit 7 picks read when 1 and write when 0, resetting to 0.
// (RULE_06) Command bits 5:0 pick one of 64 entries and bit 6 is reserved.
// (RULE_07) For a read the host issues the command, waits for pending to clear, then reads the data.
// (RULE_08) For a write the host loads write data, writes the command, then waits for pending to clear.
// (RULE_09) The write data register holds a 3-bit priority that a table write stores.
// (RULE_10) The read data register shows the priority of the last completed table read.
// (RULE_11) The table is not initialised at reset and the host must fill it before use.
// (RULE_12) The table status pending bit is set during an access and clears itself at its end.
// (RULE_13) A member flag admits matching ingress packets, otherwise only admit-non-member does.
// (RULE_14) With IP priority on and precedence off, IPv4 priority comes from the table.
// (RULE_15) A command written while pending is set is ignored.
`timescale 1ns/1ps
`default_nettype none
`include "pta_defines.svh"

module pta_top #(
  parameter int DEPTH = 64,
  parameter int PW    = 3
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // APB slave
  input  wire logic [15:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // VLAN engine
  input  wire logic        vlan_cmd_start,
  input  wire logic        vlan_cmd_done,
  input  wire logic [17:0] vlan_rd_word,
  input  wire logic [2:0]  admit_non_member,
  output logic      [2:0]  vlan_member,
  output logic      [2:0]  vlan_untag,
  output logic      [2:0]  vlan_admit,
  // Ingress priority
  input  wire logic        use_ip,
  input  wire logic        use_precedence,
  input  wire logic        ipv4_valid,
  input  wire logic [7:0]  ipv4_tos,
  output logic             tx_prio_valid,
  output logic      [2:0]  tx_prio
);

  localparam int AW = $clog2(DEPTH);

  function automatic logic [15:0] pta_byte_addr(input logic [15:0] idx);
    pta_byte_addr = {idx[13:0], 2'b00};
  endfunction : pta_byte_addr

  // Bus phases
  logic apb_setup;
  logic apb_wr;
  logic cmd_wr;
  logic cmd_take;

  assign pready    = 1'b1;
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;
  assign cmd_wr    = apb_wr && (paddr == pta_byte_addr(`PTA_IDX_TBL_CMD));

  // Table access, VLAN and read mux state
  pta_pkg::pta_state_t state_reg, state_next;
  logic          pend_reg, pend_next;
  logic          rnw_reg, rnw_next;
  logic [AW-1:0] idx_reg, idx_next;
  logic [PW-1:0] wdat_reg, wdat_next;
  logic [PW-1:0] rdat_reg, rdat_next;
  logic          vpend_reg, vpend_next;
  logic [17:0]   vword_reg, vword_next;
  logic [2:0]    admit_reg, admit_next;
  logic [31:0]   prdata_reg, prdata_next;
  logic          perr_reg, perr_next;

  // Table port signals
  logic          mem_en;
  logic          mem_we;
  logic [PW-1:0] mem_rdata;
  logic [AW-1:0] lk_addr;
  logic [PW-1:0] lk_prio;

  assign cmd_take = cmd_wr && !pend_reg; // RULE_15
  assign mem_en   = (state_reg == pta_pkg::PTA_ACCESS);
  assign mem_we   = mem_en && !rnw_reg; // RULE_05

  always_comb begin
    state_next = state_reg;
    pend_next  = pend_reg;
    rnw_next   = rnw_reg;
    idx_next   = idx_reg;
    rdat_next  = rdat_reg;
    case (state_reg)
      pta_pkg::PTA_IDLE: begin
        if (cmd_take) begin
          rnw_next   = pwdata[`PTA_CMD_RNW_BIT]; // RULE_04
          idx_next   = pwdata[`PTA_CMD_IDX_MSB:0]; // RULE_06
          pend_next  = 1'b1; // RULE_12
          state_next = pta_pkg::PTA_ACCESS;
        end
      end
      pta_pkg::PTA_ACCESS: begin
        state_next = pta_pkg::PTA_DONE;
      end
      pta_pkg::PTA_DONE: begin
        if (rnw_reg) begin
          rdat_next = mem_rdata; // RULE_10
        end
        pend_next  = 1'b0; // RULE_12
        state_next = pta_pkg::PTA_IDLE;
      end
      default: begin
        pend_next  = 1'b0;
        state_next = pta_pkg::PTA_IDLE;
      end
    endcase
  end

  // Write data and VLAN state
  always_comb begin
    wdat_next = wdat_reg;
    if (apb_wr && (paddr == pta_byte_addr(`PTA_IDX_TBL_WDATA))) begin
      wdat_next = pwdata[`PTA_PRIO_MSB:0]; // RULE_09
    end
    vpend_next = vpend_reg;
    if (vlan_cmd_done) begin
      vpend_next = 1'b0;
    end
    if (vlan_cmd_start) begin
      vpend_next = 1'b1; // RULE_01
    end
    vword_next = vlan_rd_word;
    admit_next = admit_non_member;
  end

  // Read mux, captured in the setup phase
  always_comb begin
    prdata_next = prdata_reg;
    perr_next   = perr_reg;
    if (apb_setup) begin
      prdata_next = `PTA_DATA_ZERO;
      perr_next   = 1'b0;
      if (paddr == pta_byte_addr(`PTA_IDX_VLAN_RD)) begin
        prdata_next[`PTA_VLAN_MSB:0] = vword_reg;
      end else if (paddr == pta_byte_addr(`PTA_IDX_VLAN_STS)) begin
        prdata_next[`PTA_PEND_BIT] = vpend_reg; // RULE_01
      end else if (paddr == pta_byte_addr(`PTA_IDX_TBL_CMD)) begin
        prdata_next[`PTA_CMD_RNW_BIT] = rnw_reg;
        prdata_next[`PTA_CMD_IDX_MSB:0] = idx_reg;
      end else if (paddr == pta_byte_addr(`PTA_IDX_TBL_WDATA)) begin
        prdata_next[`PTA_PRIO_MSB:0] = wdat_reg;
      end else if (paddr == pta_byte_addr(`PTA_IDX_TBL_RDATA)) begin
        prdata_next[`PTA_PRIO_MSB:0] = rdat_reg;
      end else if (paddr == pta_byte_addr(`PTA_IDX_TBL_STS)) begin
        prdata_next[`PTA_PEND_BIT] = pend_reg; // RULE_12
      end else begin
        perr_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg  <= pta_pkg::PTA_IDLE;
      pend_reg   <= 1'b0;
      rnw_reg    <= 1'b0;
      idx_reg    <= '0;
      wdat_reg   <= `PTA_PRIO_RST;
      rdat_reg   <= `PTA_PRIO_RST;
      vpend_reg  <= 1'b0;
      vword_reg  <= `PTA_VLAN_RST;
      admit_reg  <= 3'h0;
      prdata_reg <= `PTA_DATA_ZERO;
      perr_reg   <= 1'b0;
    end else begin
      state_reg  <= state_next;
      pend_reg   <= pend_next;
      rnw_reg    <= rnw_next;
      idx_reg    <= idx_next;
      wdat_reg   <= wdat_next;
      rdat_reg   <= rdat_next;
      vpend_reg  <= vpend_next;
      vword_reg  <= vword_next;
      admit_reg  <= admit_next;
      prdata_reg <= prdata_next;
      perr_reg   <= perr_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pslverr = perr_reg && psel && penable;

  // VLAN entry fields
  assign vlan_member = {vword_reg[`PTA_VLAN_MEM2_BIT],
                        vword_reg[`PTA_VLAN_MEM1_BIT],
                        vword_reg[`PTA_VLAN_MEM0_BIT]}; // RULE_03
  assign vlan_untag  = {vword_reg[`PTA_VLAN_UNT2_BIT], // RULE_02
                        vword_reg[`PTA_VLAN_UNT1_BIT],
                        vword_reg[`PTA_VLAN_UNT0_BIT]}; // RULE_03
  assign vlan_admit  = vlan_member | admit_reg; // RULE_13

  // Storage is left unreset
  pta_table_mem #(
    .DEPTH (DEPTH),
    .WIDTH (PW),
    .AW    (AW)
  ) u_mem (
    .clk        (clk),
    .host_en    (mem_en),
    .host_we    (mem_we), // RULE_11
    .host_addr  (idx_reg),
    .host_wdata (wdat_reg),
    .host_rdata (mem_rdata),
    .lk_addr    (lk_addr),
    .lk_rdata   (lk_prio)
  );

  pta_prio_select u_sel (
    .clk            (clk),
    .reset          (reset),
    .use_ip         (use_ip),
    .use_precedence (use_precedence),
    .ipv4_valid     (ipv4_valid),
    .ipv4_tos       (ipv4_tos),
    .tx_prio_valid  (tx_prio_valid),
    .tx_prio        (tx_prio),
    .lk_addr        (lk_addr),
    .lk_prio        (lk_prio)
  );

  property p_cmd_pending;
    @(posedge clk) disable iff (reset)
    cmd_take |=> pend_reg && rnw_reg == $past(pwdata[7]) && idx_reg == $past(pwdata[5:0]);
  endproperty
  a_cmd_pending: assert property (p_cmd_pending) else $error("command not started"); // RULE_04

  property p_pend_len;
    @(posedge clk) disable iff (reset)
    $rose(pend_reg) |-> pend_reg [*2] ##1 !pend_reg;
  endproperty
  a_pend_len: assert property (p_pend_len) else $error("pending length wrong"); // RULE_12

  property p_ignore_busy;
    @(posedge clk) disable iff (reset)
    cmd_wr && pend_reg |=> rnw_reg == $past(rnw_reg) && idx_reg == $past(idx_reg);
  endproperty
  a_ignore_busy: assert property (p_ignore_busy) else $error("busy command taken"); // RULE_15

  property p_vlan_set;
    @(posedge clk) disable iff (reset)
    vlan_cmd_start |=> vpend_reg;
  endproperty
  a_vlan_set: assert property (p_vlan_set) else $error("vlan pending not set"); // RULE_01

  property p_vlan_clear;
    @(posedge clk) disable iff (reset)
    vlan_cmd_done && !vlan_cmd_start |=> !vpend_reg;
  endproperty
  a_vlan_clear: assert property (p_vlan_clear) else $error("vlan pending not cleared"); // RULE_01

  property p_untag2;
    @(posedge clk) disable iff (reset)
    1'b1 |=> vlan_untag[2] == $past(vlan_rd_word[16]);
  endproperty
  a_untag2: assert property (p_untag2) else $error("port 2 untag wrong"); // RULE_02

  property p_port10;
    @(posedge clk) disable iff (reset)
    1'b1 |=> {vlan_member[1], vlan_untag[1], vlan_member[0], vlan_untag[0]} == $past(vlan_rd_word[15:12]);
  endproperty
  a_port10: assert property (p_port10) else $error("port 1/0 flags wrong"); // RULE_03

  property p_admit;
    @(posedge clk) disable iff (reset)
    $past(vlan_rd_word[17]) |-> vlan_admit[2];
  endproperty
  a_admit: assert property (p_admit) else $error("member not admitted"); // RULE_13

  property p_wdata;
    @(posedge clk) disable iff (reset)
    apb_wr && paddr == pta_byte_addr(`PTA_IDX_TBL_WDATA) |=> wdat_reg == $past(pwdata[2:0]);
  endproperty
  a_wdata: assert property (p_wdata) else $error("write data not held"); // RULE_09

  property p_rdata_hold;
    @(posedge clk) disable iff (reset)
    state_reg != pta_pkg::PTA_DONE |=> $stable(rdat_reg);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed early"); // RULE_10

  property p_cmd_strobe;
    @(posedge clk) disable iff (reset)
    cmd_take |=> (mem_en && mem_we != $past(pwdata[`PTA_CMD_RNW_BIT])) ##1 !mem_en;
  endproperty
  a_cmd_strobe: assert property (p_cmd_strobe) else $error("table strobe wrong"); // RULE_05

  property p_read_capture;
    @(posedge clk) disable iff (reset)
    state_reg == pta_pkg::PTA_DONE && rnw_reg |=> rdat_reg == $past(mem_rdata);
  endproperty
  a_read_capture: assert property (p_read_capture) else $error("table read not captured"); // RULE_10

  property p_write_keeps_read;
    @(posedge clk) disable iff (reset)
    state_reg == pta_pkg::PTA_DONE && !rnw_reg |=> $stable(rdat_reg);
  endproperty
  a_write_keeps_read: assert property (p_write_keeps_read) else $error("read data changed by write"); // RULE_10

  property p_pend_state;
    @(posedge clk) disable iff (reset)
    pend_reg == (state_reg != pta_pkg::PTA_IDLE);
  endproperty
  a_pend_state: assert property (p_pend_state) else $error("pending out of step"); // RULE_12

  property p_status_read;
    @(posedge clk) disable iff (reset)
    apb_setup && paddr == pta_byte_addr(`PTA_IDX_TBL_STS) |=> prdata == 32'($past(pend_reg));
  endproperty
  a_status_read: assert property (p_status_read) else $error("table status read wrong"); // RULE_12

  property p_vlan_status_read;
    @(posedge clk) disable iff (reset)
    apb_setup && paddr == pta_byte_addr(`PTA_IDX_VLAN_STS) |=> prdata == 32'($past(vpend_reg));
  endproperty
  a_vlan_status_read: assert property (p_vlan_status_read) else $error("vlan status read wrong"); // RULE_01

  property p_cmd_readback;
    @(posedge clk) disable iff (reset)
    apb_setup && paddr == pta_byte_addr(`PTA_IDX_TBL_CMD) |=> !prdata[`PTA_CMD_RNW_BIT - 1] &&
      prdata[`PTA_CMD_RNW_BIT] == $past(rnw_reg) && prdata[`PTA_CMD_IDX_MSB:0] == $past(idx_reg);
  endproperty
  a_cmd_readback: assert property (p_cmd_readback) else $error("command readback wrong"); // RULE_06

  property p_table_path;
    @(posedge clk) disable iff (reset)
    ipv4_valid && use_ip && !use_precedence |-> ##2 tx_prio_valid && tx_prio == $past(lk_prio);
  endproperty
  a_table_path: assert property (p_table_path) else $error("table priority wrong"); // RULE_14

  property p_no_prio;
    @(posedge clk) disable iff (reset)
    !(ipv4_valid && use_ip) |-> ##2 !tx_prio_valid;
  endproperty
  a_no_prio: assert property (p_no_prio) else $error("stray priority"); // RULE_14

endmodule : pta_top

`default_nettype wire

// *** tb/pta_testbench.sv ***
// Self-checking bench for the priority table access block.
// Assumes pta_top with a zero-wait APB slave and the hand-over timing.
`timescale 1ns/1ps
`default_nettype none
`include "pta_defines.svh"

module testbench;
  localparam logic [15:0] A_VRD = 16'(`PTA_IDX_VLAN_RD * 4);
  localparam logic [15:0] A_VST = 16'(`PTA_IDX_VLAN_STS * 4);
  localparam logic [15:0] A_CMD = 16'(`PTA_IDX_TBL_CMD * 4);
  localparam logic [15:0] A_WD  = 16'(`PTA_IDX_TBL_WDATA * 4);
  localparam logic [15:0] A_RD  = 16'(`PTA_IDX_TBL_RDATA * 4);
  localparam logic [15:0] A_ST  = 16'(`PTA_IDX_TBL_STS * 4);
  localparam logic [15:0] A_BAD = 16'h0100;

  logic        clk, reset, psel, penable, pwrite, pready, pslverr, er;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        vlan_cmd_start, vlan_cmd_done;
  logic [17:0] vlan_rd_word;
  logic [2:0]  admit_non_member, vlan_member, vlan_untag, vlan_admit;
  logic        use_ip, use_precedence, ipv4_valid, tx_prio_valid;
  logic [7:0]  ipv4_tos;
  logic [2:0]  tx_prio;
  int          err_total, checked, cycles;

  pta_top #(.DEPTH(64), .PW(3)) i_dut (
    .clk(clk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vlan_cmd_start(vlan_cmd_start), .vlan_cmd_done(vlan_cmd_done), .vlan_rd_word(vlan_rd_word),
    .admit_non_member(admit_non_member), .vlan_member(vlan_member), .vlan_untag(vlan_untag),
    .vlan_admit(vlan_admit), .use_ip(use_ip), .use_precedence(use_precedence),
    .ipv4_valid(ipv4_valid), .ipv4_tos(ipv4_tos), .tx_prio_valid(tx_prio_valid), .tx_prio(tx_prio));

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      $display("MISMATCH run time expected below 20000 cycles seen %0d", cycles);
      test_done();
    end
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [2:0] pr(input int i);
    return 3'(i ^ (i >> 3));
  endfunction : pr

  // One APB transfer; entered just after a rising edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, input bit chain);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    penable <= 1'b0;
    if (!chain) begin
      psel <= 1'b0;
      @(posedge clk);
    end
  endtask : apb

  task automatic wait_tbl();
    int n;
    n = 0;
    do begin
      apb(1'b0, A_ST, 32'h0, 1'b0);
      n++;
    end while (rd[0] !== 1'b0 && n < 20);
    chk("table pending cleared", 32'h0, rd);
  endtask : wait_tbl

  // Issue a command, see pending high in the next transfer, poll it low
  task automatic tbl_cmd(input logic [31:0] cmd);
    apb(1'b1, A_CMD, cmd, 1'b1);
    apb(1'b0, A_ST, 32'h0, 1'b0);
    chk("table pending set", 32'h1, rd);
    wait_tbl();
  endtask : tbl_cmd

  task automatic t_reset();
    logic [15:0] al[6];
    al = '{A_VRD, A_VST, A_CMD, A_WD, A_RD, A_ST};
    foreach (al[k]) begin
      apb(1'b0, al[k], 32'h0, 1'b0);
      chk("register reset value", 32'h0, rd);
      chk("no error on mapped read", 32'h0, {31'h0, er});
    end
  endtask : t_reset

  task automatic t_fill_table();
    for (int i = 0; i < 64; i++) begin
      apb(1'b1, A_WD, {29'h0, pr(i)}, 1'b0);
      apb(1'b0, A_WD, 32'h0, 1'b0);
      chk("write data readback", {29'h0, pr(i)}, rd);
      tbl_cmd(32'(i));
    end
    for (int i = 63; i >= 0; i--) begin
      tbl_cmd(32'h80 | 32'(i));
      apb(1'b0, A_RD, 32'h0, 1'b0);
      chk("table read data", {29'h0, pr(i)}, rd);
    end
    apb(1'b0, A_CMD, 32'h0, 1'b0);
    chk("command readback", 32'h80, rd);
  endtask : t_fill_table

  task automatic t_reserved_bits();
    tbl_cmd(32'hFFFF_FFC5);
    apb(1'b0, A_CMD, 32'h0, 1'b0);
    chk("command reserved bits", 32'h85, rd);
    apb(1'b0, A_RD, 32'h0, 1'b0);
    chk("read of index 5", {29'h0, pr(5)}, rd);
    apb(1'b1, A_WD, 32'hFFFF_FFFF, 1'b0);
    apb(1'b0, A_WD, 32'h0, 1'b0);
    chk("write data width", 32'h7, rd);
  endtask : t_reserved_bits

  task automatic t_busy_ignored();
    apb(1'b1, A_WD, {29'h0, ~pr(10)}, 1'b0);
    apb(1'b1, A_CMD, 32'h89, 1'b1);
    apb(1'b1, A_CMD, 32'h0A, 1'b0);
    wait_tbl();
    apb(1'b0, A_CMD, 32'h0, 1'b0);
    chk("command after busy write", 32'h89, rd);
    apb(1'b0, A_RD, 32'h0, 1'b0);
    chk("read data of index 9", {29'h0, pr(9)}, rd);
    tbl_cmd(32'h8A);
    apb(1'b0, A_RD, 32'h0, 1'b0);
    chk("index 10 untouched", {29'h0, pr(10)}, rd);
  endtask : t_busy_ignored

  task automatic t_readonly_and_unmapped();
    apb(1'b1, A_RD, 32'h0, 1'b0);
    apb(1'b1, A_ST, 32'h1, 1'b0);
    apb(1'b1, A_VST, 32'h1, 1'b0);
    apb(1'b0, A_RD, 32'h0, 1'b0);
    chk("read data is read-only", {29'h0, pr(10)}, rd);
    apb(1'b0, A_ST, 32'h0, 1'b0);
    chk("table status is read-only", 32'h0, rd);
    apb(1'b0, A_VST, 32'h0, 1'b0);
    chk("vlan status is read-only", 32'h0, rd);
    apb(1'b1, A_BAD, 32'hFFFF_FFFF, 1'b0);
    chk("unmapped write error", 32'h1, {31'h0, er});
    apb(1'b0, A_BAD, 32'h0, 1'b0);
    chk("unmapped read error", 32'h1, {31'h0, er});
    chk("unmapped read data", 32'h0, rd);
  endtask : t_readonly_and_unmapped

  task automatic t_vlan();
    logic [2:0] m, u, a;
    for (int p = 0; p < 3; p++) begin
      m = 3'(1 << p);
      u = 3'(1 << ((p + 1) % 3));
      a = 3'(1 << ((p + 2) % 3));
      vlan_rd_word     <= 18'(1 << (13 + 2 * p)) | 18'(1 << (12 + 2 * ((p + 1) % 3))) | 18'hABC;
      admit_non_member <= a;
      repeat (3) @(posedge clk);
      chk("member flags", {29'h0, m}, {29'h0, vlan_member});
      chk("untag flags", {29'h0, u}, {29'h0, vlan_untag});
      chk("admit flags", {29'h0, m | a}, {29'h0, vlan_admit});
      apb(1'b0, A_VRD, 32'h0, 1'b0);
      chk("vlan read word", {14'h0, vlan_rd_word}, rd);
    end
    vlan_cmd_start <= 1'b1;
    @(posedge clk);
    vlan_cmd_start <= 1'b0;
    apb(1'b0, A_VST, 32'h0, 1'b0);
    chk("vlan pending set", 32'h1, rd);
    apb(1'b0, A_VST, 32'h0, 1'b0);
    chk("vlan pending held", 32'h1, rd);
    vlan_cmd_done <= 1'b1;
    @(posedge clk);
    vlan_cmd_done <= 1'b0;
    apb(1'b0, A_VST, 32'h0, 1'b0);
    chk("vlan pending cleared", 32'h0, rd);
  endtask : t_vlan

  task automatic send(input logic [7:0] tos, output logic v, output logic [2:0] p);
    ipv4_valid <= 1'b1;
    ipv4_tos   <= tos;
    @(posedge clk);
    ipv4_valid <= 1'b0;
    v = 1'b0;
    p = 3'h0;
    for (int n = 0; n < 4 && !v; n++) begin
      @(negedge clk);
      v = (tx_prio_valid === 1'b1);
      p = tx_prio;
      @(posedge clk);
    end
  endtask : send

  task automatic t_priority();
    logic       v;
    logic [2:0] p;
    logic [7:0] tl[4];
    tl = '{8'h00, 8'hFF, 8'hB8, 8'h5D};
    use_ip <= 1'b1;
    foreach (tl[k]) begin
      use_precedence <= 1'b0;
      send(tl[k], v, p);
      chk("table priority valid", 32'h1, {31'h0, v});
      chk("table priority", {29'h0, pr(int'(tl[k][7:2]))}, {29'h0, p});
      use_precedence <= 1'b1;
      send(tl[k], v, p);
      chk("precedence priority", {29'h0, tl[k][7:5]}, {29'h0, p});
    end
    use_ip <= 1'b0;
    send(8'hB8, v, p);
    chk("no priority without ip", 32'h0, {31'h0, v});
  endtask : t_priority

  initial begin
    clk = 1'b0; reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 16'h0000; pwdata = 32'h0; vlan_cmd_start = 1'b0; vlan_cmd_done = 1'b0;
    vlan_rd_word = 18'h00000; admit_non_member = 3'h0; use_ip = 1'b0; use_precedence = 1'b1;
    ipv4_valid = 1'b0; ipv4_tos = 8'h00; err_total = 0; checked = 0; cycles = 0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_fill_table();
    t_reserved_bits();
    t_busy_ignored();
    t_readonly_and_unmapped();
    t_vlan();
    t_priority();
    test_done();
  end
endmodule : testbench

`default_nettype wire
